// ==== include/lbrc_pkg.sv ====
package lbrc_pkg;

    // Global address map: two windows onto the same registers
    localparam int unsigned ADDR_W            = 16;
    localparam logic [15:0] BASE_BLOCKING     = 16'h0200;
    localparam logic [15:0] BASE_NONBLOCKING  = 16'h0300;
    localparam logic [15:0] OFF_STATUS_TWO    = 16'h0045;
    localparam logic [15:0] OFF_CONTROL_THREE = 16'h0046;

    localparam logic [7:0] RST_STATUS_TWO     = 8'h00;
    localparam logic [7:0] RST_CONTROL_THREE  = 8'h00;

    // Status two field positions
    localparam int unsigned S2_LIN_BREAK_FLAG = 7;
    localparam int unsigned S2_RX_EDGE_FLAG   = 6;
    localparam int unsigned S2_RX_INVERT      = 4;
    localparam int unsigned S2_IDLE_REPORT    = 3;
    localparam int unsigned S2_LONG_BREAK     = 2;
    localparam int unsigned S2_BREAK_DET_EN   = 1;
    localparam int unsigned S2_RX_ACTIVE      = 0;

    // Control three field positions
    localparam int unsigned C3_RX_NINTH       = 7;
    localparam int unsigned C3_TX_NINTH       = 6;
    localparam int unsigned C3_TX_DIR         = 5;
    localparam int unsigned C3_TX_INVERT      = 4;
    localparam int unsigned C3_OVERRUN_IE     = 3;
    localparam int unsigned C3_NOISE_IE       = 2;
    localparam int unsigned C3_FRAMING_IE     = 1;
    localparam int unsigned C3_PARITY_IE      = 0;

    // Lengths in bit times
    localparam logic [3:0] BRK_LEN_SHORT_8    = 4'hA;
    localparam logic [3:0] BRK_LEN_SHORT_9    = 4'hB;
    localparam logic [3:0] BRK_LEN_LONG_8     = 4'hD;
    localparam logic [3:0] BRK_LEN_LONG_9     = 4'hE;
    localparam logic [3:0] CHAR_LEN_8         = 4'hA;
    localparam logic [3:0] CHAR_LEN_9         = 4'hB;
    localparam logic [3:0] BRK_DET_NORMAL     = 4'hA;
    localparam logic [3:0] BRK_DET_LIN        = 4'hB;

endpackage

// ==== design/lbrc_sync.sv ====
`timescale 1ns/1ps
module lbrc_sync
    import lbrc_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b1
)
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      level_o
);

    logic meta_q;
    logic sync_q;
    logic hold_q;
    logic level_q;

    // Only the second stage reads the first
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_q <= RESET_LEVEL;
            sync_q <= RESET_LEVEL;
            hold_q <= RESET_LEVEL;
        end
        else
        begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            hold_q <= sync_q;
        end
    end

    // A change is taken once the last two stages agree
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            level_q <= RESET_LEVEL;
        else if (sync_q == hold_q)
            level_q <= hold_q;
    end

    assign level_o = level_q;

endmodule

// ==== design/lbrc_run_counter.sv ====
`timescale 1ns/1ps
module lbrc_run_counter
    import lbrc_pkg::*;
#(
    parameter int unsigned WIDTH = 4
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             tick_i,
    input  wire logic             run_i,
    input  wire logic [WIDTH-1:0] limit_i,
    output logic                  hit_o
);

    logic [WIDTH-1:0] cnt_q;
    logic             hit_q;
    logic             last;

    assign last = (cnt_q == limit_i - WIDTH'(1));

    // Saturates at the limit so one long run reports only once
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_q <= '0;
        else if (!run_i)
            cnt_q <= '0;
        else if (tick_i && cnt_q != limit_i)
            cnt_q <= cnt_q + WIDTH'(1);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            hit_q <= 1'b0;
        else
            hit_q <= run_i && tick_i && last;
    end

    assign hit_o = hit_q;

endmodule

// ==== design/lbrc_top.sv ====
`timescale 1ns/1ps
module lbrc_top
    import lbrc_pkg::*;
(
    input  wire logic              CLK_I,
    input  wire logic              RST_I,
    input  wire logic [ADDR_W-1:0] BUS_ADDR_I,
    input  wire logic              BUS_WR_I,
    input  wire logic              BUS_RD_I,
    input  wire logic [7:0]        BUS_WDATA_I,
    output logic      [7:0]        BUS_RDATA_O,
    output logic                   BUS_HIT_O,
    input  wire logic              RXD_I,
    input  wire logic              TXD_I,
    output logic                   TXD_O,
    output logic                   TXD_OE_N_O,
    input  wire logic              BIT_TICK_I,
    input  wire logic              NINE_BIT_I,
    input  wire logic              LOOP_SEL_I,
    input  wire logic              LOOP_SRC_I,
    input  wire logic              TX_EN_I,
    input  wire logic              TX_SERIAL_I,
    input  wire logic              RX_STANDBY_I,
    input  wire logic              RX_ACTIVE_I,
    input  wire logic              RX_LOAD_I,
    input  wire logic              RX_NINTH_I,
    input  wire logic              FRAME_ERR_I,
    input  wire logic              DATA_WR_I,
    input  wire logic              OVERRUN_FLAG_I,
    input  wire logic              NOISE_FLAG_I,
    input  wire logic              FRAMING_FLAG_I,
    input  wire logic              PARITY_FLAG_I,
    output logic                   RX_LINE_O,
    output logic                   RX_FULL_SET_O,
    output logic                   FRAME_ERR_SET_O,
    output logic                   IDLE_SET_O,
    output logic                   BREAK_DET_O,
    output logic      [3:0]        BREAK_LEN_O,
    output logic      [3:0]        TX_SHIFT_LEN_O,
    output logic                   TX_NINTH_O,
    output logic                   IRQ_O
);

    logic       lin_break_flag_q;
    logic       rx_edge_flag_q;
    logic       rx_polarity_invert_q;
    logic       standby_idle_report_q;
    logic       long_break_select_q;
    logic       lin_break_detect_en_q;
    logic       rx_ninth_bit_q;
    logic       tx_ninth_bit_q;
    logic       single_wire_tx_dir_q;
    logic       tx_polarity_invert_q;
    logic [3:0] err_irq_en_q;
    logic [7:0] rdata_q;
    logic       hit_q;
    logic       rx_line_q;
    logic       rx_line_prev_q;
    logic       idle_armed_q;
    logic       txd_q;
    logic       tx_ninth_q;
    logic [3:0] brk_len_q;
    logic [3:0] shift_len_q;
    logic       irq_q;
    logic       rxd_level;
    logic       txd_level;
    logic       rx_line;
    logic       sel_s2;
    logic       sel_c3;
    logic       wr_s2;
    logic       wr_c3;
    logic       single_wire;
    logic       active_edge;
    logic       brk_hit;
    logic       idle_hit;
    logic [3:0] brk_limit;
    logic [3:0] char_len;
    logic [3:0] err_flags;
    logic [7:0] status_two;
    logic [7:0] control_three;

    lbrc_sync #(.RESET_LEVEL(1'b1)) u_rxd_sync
    (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .pin_i   (RXD_I),
        .level_o (rxd_level)
    );

    lbrc_sync #(.RESET_LEVEL(1'b1)) u_txd_sync
    (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .pin_i   (TXD_I),
        .level_o (txd_level)
    );

    // Register decode through either window
    assign sel_s2 = (BUS_ADDR_I == BASE_BLOCKING + OFF_STATUS_TWO)
                 || (BUS_ADDR_I == BASE_NONBLOCKING + OFF_STATUS_TWO);
    assign sel_c3 = (BUS_ADDR_I == BASE_BLOCKING + OFF_CONTROL_THREE)
                 || (BUS_ADDR_I == BASE_NONBLOCKING + OFF_CONTROL_THREE);
    assign wr_s2  = BUS_WR_I && sel_s2;
    assign wr_c3  = BUS_WR_I && sel_c3;

    assign single_wire = LOOP_SEL_I && LOOP_SRC_I;

    // In single-wire mode the transmit pin is the receive source
    assign rx_line = (single_wire ? txd_level : rxd_level)
                   ^ rx_polarity_invert_q;

    // Falling edge after inversion covers both pin polarities
    assign active_edge = rx_line_prev_q && !rx_line_q;

    assign brk_limit = lin_break_detect_en_q ? BRK_DET_LIN
                                             : BRK_DET_NORMAL;
    assign char_len  = NINE_BIT_I ? CHAR_LEN_9 : CHAR_LEN_8;

    lbrc_run_counter #(.WIDTH(4)) u_low_run
    (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .tick_i  (BIT_TICK_I),
        .run_i   (!rx_line_q),
        .limit_i (brk_limit),
        .hit_o   (brk_hit)
    );

    lbrc_run_counter #(.WIDTH(4)) u_high_run
    (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .tick_i  (BIT_TICK_I),
        .run_i   (rx_line_q && idle_armed_q),
        .limit_i (char_len),
        .hit_o   (idle_hit)
    );

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            rx_line_q      <= 1'b1;
            rx_line_prev_q <= 1'b1;
        end
        else
        begin
            rx_line_q      <= rx_line;
            rx_line_prev_q <= rx_line_q;
        end
    end

    // Idle is reported once per quiet period, after some activity, unless in standby with the idle report bit clear
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            idle_armed_q <= 1'b0;
        else if (!rx_line_q)
            idle_armed_q <= 1'b1;
        else if (idle_hit)
            idle_armed_q <= 1'b0;
    end

    assign IDLE_SET_O = idle_hit
                     && (!RX_STANDBY_I || standby_idle_report_q);

    // Break in data is not a received character while detecting
    assign RX_FULL_SET_O   = RX_LOAD_I && !lin_break_detect_en_q;
    // Framing check does not look at the long break select
    assign FRAME_ERR_SET_O = FRAME_ERR_I && !lin_break_detect_en_q;
    assign BREAK_DET_O     = brk_hit;

    // Hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            lin_break_flag_q <= RST_STATUS_TWO[S2_LIN_BREAK_FLAG];
        else if (brk_hit && lin_break_detect_en_q)
            lin_break_flag_q <= 1'b1;
        else if (wr_s2 && BUS_WDATA_I[S2_LIN_BREAK_FLAG])
            lin_break_flag_q <= 1'b0;
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            rx_edge_flag_q <= RST_STATUS_TWO[S2_RX_EDGE_FLAG];
        else if (active_edge)
            rx_edge_flag_q <= 1'b1;
        else if (wr_s2 && BUS_WDATA_I[S2_RX_EDGE_FLAG])
            rx_edge_flag_q <= 1'b0;
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            rx_polarity_invert_q  <= RST_STATUS_TWO[S2_RX_INVERT];
            standby_idle_report_q <= RST_STATUS_TWO[S2_IDLE_REPORT];
            long_break_select_q   <= RST_STATUS_TWO[S2_LONG_BREAK];
            lin_break_detect_en_q <= RST_STATUS_TWO[S2_BREAK_DET_EN];
        end
        else if (wr_s2)
        begin
            rx_polarity_invert_q  <= BUS_WDATA_I[S2_RX_INVERT];
            standby_idle_report_q <= BUS_WDATA_I[S2_IDLE_REPORT];
            long_break_select_q   <= BUS_WDATA_I[S2_LONG_BREAK];
            lin_break_detect_en_q <= BUS_WDATA_I[S2_BREAK_DET_EN];
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            tx_ninth_bit_q       <= RST_CONTROL_THREE[C3_TX_NINTH];
            single_wire_tx_dir_q <= RST_CONTROL_THREE[C3_TX_DIR];
            tx_polarity_invert_q <= RST_CONTROL_THREE[C3_TX_INVERT];
            err_irq_en_q         <= RST_CONTROL_THREE[3:0];
        end
        else if (wr_c3)
        begin
            tx_ninth_bit_q       <= BUS_WDATA_I[C3_TX_NINTH];
            single_wire_tx_dir_q <= BUS_WDATA_I[C3_TX_DIR];
            tx_polarity_invert_q <= BUS_WDATA_I[C3_TX_INVERT];
            err_irq_en_q         <= BUS_WDATA_I[3:0];
        end
    end

    // Read-only; overwritten by the next character loaded in nine-bit mode
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            rx_ninth_bit_q <= RST_CONTROL_THREE[C3_RX_NINTH];
        else if (RX_LOAD_I && NINE_BIT_I)
            rx_ninth_bit_q <= RX_NINTH_I;
    end

    // Sampled at the data write, so a later field write is too late
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            tx_ninth_q <= 1'b0;
        else if (DATA_WR_I && NINE_BIT_I)
            tx_ninth_q <= tx_ninth_bit_q;
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            brk_len_q   <= BRK_LEN_SHORT_8;
            shift_len_q <= CHAR_LEN_8;
        end
        else
        begin
            unique case ({long_break_select_q, NINE_BIT_I})
                2'b00: brk_len_q <= BRK_LEN_SHORT_8;
                2'b01: brk_len_q <= BRK_LEN_SHORT_9;
                2'b10: brk_len_q <= BRK_LEN_LONG_8;
                2'b11: brk_len_q <= BRK_LEN_LONG_9;
            endcase
            shift_len_q <= char_len;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            txd_q <= 1'b1;
        else
            txd_q <= TX_SERIAL_I ^ tx_polarity_invert_q;
    end

    assign TXD_OE_N_O = single_wire ? !single_wire_tx_dir_q
                                    : !TX_EN_I;

    assign err_flags = {OVERRUN_FLAG_I, NOISE_FLAG_I,
                        FRAMING_FLAG_I, PARITY_FLAG_I};

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            irq_q <= 1'b0;
        else
            irq_q <= |(err_flags & err_irq_en_q);
    end

    assign status_two = {lin_break_flag_q, rx_edge_flag_q, 1'b0,
                         rx_polarity_invert_q, standby_idle_report_q,
                         long_break_select_q, lin_break_detect_en_q,
                         RX_ACTIVE_I};
    assign control_three = {rx_ninth_bit_q, tx_ninth_bit_q,
                            single_wire_tx_dir_q, tx_polarity_invert_q,
                            err_irq_en_q};

    // Unmapped addresses read zero and do not raise the hit flag
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            rdata_q <= 8'h00;
            hit_q   <= 1'b0;
        end
        else
        begin
            hit_q <= (BUS_RD_I || BUS_WR_I) && (sel_s2 || sel_c3);
            if (BUS_RD_I)
                rdata_q <= sel_s2 ? status_two
                         : sel_c3 ? control_three : 8'h00;
        end
    end

    assign BUS_RDATA_O    = rdata_q;
    assign BUS_HIT_O      = hit_q;
    assign RX_LINE_O      = rx_line_q;
    assign TXD_O          = txd_q;
    assign TX_NINTH_O     = tx_ninth_q;
    assign BREAK_LEN_O    = brk_len_q;
    assign TX_SHIFT_LEN_O = shift_len_q;
    assign IRQ_O          = irq_q;

    default clocking chk_cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    chk_brk_flag_set: assert property
        (brk_hit && lin_break_detect_en_q |=> lin_break_flag_q)
        else $error("break flag not set");
    chk_brk_flag_hold: assert property
        (lin_break_flag_q && !wr_s2 |=> lin_break_flag_q)
        else $error("break flag lost without clear");
    chk_edge_flag_set: assert property
        ($fell(rx_line_q) |=> rx_edge_flag_q)
        else $error("edge flag not set");
    // Source switch between the pins would look like a polarity fault
    chk_rx_invert_path: assert property
        (!single_wire && !$past(single_wire) && $stable(rx_polarity_invert_q)
        |-> RX_LINE_O == ($past(rxd_level) ^ rx_polarity_invert_q))
        else $error("receive line polarity wrong");
    chk_idle_standby: assert property
        (RX_STANDBY_I && !standby_idle_report_q |-> !IDLE_SET_O)
        else $error("idle reported in standby");
    chk_break_length: assert property
        (long_break_select_q && NINE_BIT_I |=> BREAK_LEN_O == 4'hE)
        else $error("long nine-bit break length wrong");
    chk_fe_rx_full_flag_block: assert property
        (lin_break_detect_en_q |-> !FRAME_ERR_SET_O && !RX_FULL_SET_O)
        else $error("flag set during break detect");
    chk_brk_threshold: assert property
        (lin_break_detect_en_q |-> brk_limit == 4'hB)
        else $error("break threshold not eleven");
    chk_rx_ninth_load: assert property
        (RX_LOAD_I && NINE_BIT_I |=> rx_ninth_bit_q == $past(RX_NINTH_I))
        else $error("ninth receive bit not captured");
    chk_tx_ninth_load: assert property
        (DATA_WR_I && NINE_BIT_I |=> TX_NINTH_O == $past(tx_ninth_bit_q))
        else $error("ninth transmit bit not loaded");
    chk_single_wire_dir: assert property
        (single_wire |-> TXD_OE_N_O == !single_wire_tx_dir_q)
        else $error("single-wire direction wrong");
    // Pin still shows its reset level on the first edge after release
    chk_tx_invert_out: assert property
        (!$past(RST_I) && $stable(tx_polarity_invert_q)
        |-> TXD_O == ($past(TX_SERIAL_I) ^ tx_polarity_invert_q))
        else $error("transmit polarity wrong");
    chk_overrun_irq: assert property
        (OVERRUN_FLAG_I && err_irq_en_q[3] |=> IRQ_O)
        else $error("overrun request missing");
    chk_err_irq_gate: assert property
        ((err_flags & err_irq_en_q) == 4'h0 |=> !IRQ_O)
        else $error("request without enabled flag");
    chk_decode_write: assert property
        (BUS_WR_I && BUS_ADDR_I == 16'h0346
        |=> control_three[6:0] == $past(BUS_WDATA_I[6:0]))
        else $error("non-blocking write missed");

endmodule

// ==== bench/lbrc_lin_node.sv ====
`timescale 1ns/1ps
// Remote LIN node: drives the shared bus line in whole bit times
module lbrc_lin_node
(
    input  wire logic clk_i,
    input  wire logic tick_i,
    output logic      line_o
);
    // Bus pull-up keeps the line recessive (high) between frames
    initial line_o = 1'b1;
    // Start on a bit boundary so a level spans exactly the ticks asked for
    task automatic align();
        @(posedge clk_i iff tick_i);
        @(negedge clk_i);
    endtask
    task automatic hold(input logic lvl, input int n);
        line_o = lvl;
        repeat (n) @(posedge clk_i iff tick_i);
        @(negedge clk_i);
    endtask
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench
    import lbrc_pkg::*;
;
    logic        clk, rst, wr, rd_s, tick, nine, lsel, lsrc, txen, txser;
    logic        stby, ract, rload, r9, ferr, dwr, hit, txd, oe_n, rline;
    logic        rfs, fes, idle, bdet, t9, irq, rxd, txd_in;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, d;
    logic [3:0]  fl, blen, slen, tcnt;
    int          n_fail, n_compared, n_idle, n_brk, i0;

    lbrc_lin_node u_node (.clk_i(clk), .tick_i(tick), .line_o(rxd));
    // Open pin with pull-up: high unless the block drives it
    assign txd_in = oe_n ? 1'b1 : txd;

    lbrc_top u_dut (
        .CLK_I(clk), .RST_I(rst), .BUS_ADDR_I(addr), .BUS_WR_I(wr),
        .BUS_RD_I(rd_s), .BUS_WDATA_I(wdata), .BUS_RDATA_O(rdata),
        .BUS_HIT_O(hit), .RXD_I(rxd), .TXD_I(txd_in), .TXD_O(txd),
        .TXD_OE_N_O(oe_n), .BIT_TICK_I(tick), .NINE_BIT_I(nine),
        .LOOP_SEL_I(lsel), .LOOP_SRC_I(lsrc), .TX_EN_I(txen),
        .TX_SERIAL_I(txser), .RX_STANDBY_I(stby), .RX_ACTIVE_I(ract),
        .RX_LOAD_I(rload), .RX_NINTH_I(r9), .FRAME_ERR_I(ferr),
        .DATA_WR_I(dwr), .OVERRUN_FLAG_I(fl[3]), .NOISE_FLAG_I(fl[2]),
        .FRAMING_FLAG_I(fl[1]), .PARITY_FLAG_I(fl[0]), .RX_LINE_O(rline),
        .RX_FULL_SET_O(rfs), .FRAME_ERR_SET_O(fes), .IDLE_SET_O(idle),
        .BREAK_DET_O(bdet), .BREAK_LEN_O(blen), .TX_SHIFT_LEN_O(slen),
        .TX_NINTH_O(t9), .IRQ_O(irq)
    );

    always #5 clk = ~clk;
    // Baud stand-in: one tick every 16 cycles leaves room for the sync delay
    always @(negedge clk)
    begin
        tcnt <= tcnt + 4'h1;
        tick <= (tcnt == 4'hF);
    end
    // Pulses are counted mid-cycle, well clear of the edge that makes them
    always @(negedge clk)
    begin
        if (idle === 1'b1)
            n_idle++;
        if (bdet === 1'b1)
            n_brk++;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] m,
                          input logic [7:0] e, input string nm);
        @(negedge clk);
        addr = a;
        rd_s = 1'b1;
        @(negedge clk);
        rd_s = 1'b0;
        chk(nm, e, rdata & m);
        chk({nm, " hit"}, {7'h00, (a[7:0] != 8'h47)}, {7'h00, hit});
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    task automatic t_regs();
        rd_chk(16'h0245, 8'hFF, 8'h00, "status two reset");
        rd_chk(16'h0346, 8'hFF, 8'h00, "control three reset");
        rd_chk(16'h0247, 8'hFF, 8'h00, "unmapped read");
        ract = 1'b1;
        rd_chk(16'h0345, 8'hFF, 8'h01, "active bit");
        ract = 1'b0;
        wr_reg(16'h0346, 8'hFF);
        wr_reg(16'h0250, 8'h00);
        rd_chk(16'h0246, 8'hFF, 8'h7F, "control three rw");
        wr_reg(16'h0246, 8'h00);
    endtask

    task automatic t_edge();
        u_node.align();
        u_node.hold(1'b0, 1);
        rd_chk(16'h0245, 8'h40, 8'h40, "edge on fall");
        wr_reg(16'h0245, 8'h40);
        rd_chk(16'h0245, 8'h40, 8'h00, "edge cleared");
        u_node.hold(1'b1, 1);
        wr_reg(16'h0245, 8'h10);
        repeat (6) @(negedge clk);
        wr_reg(16'h0245, 8'h50);
        chk("inverted line", {7'h00, ~rxd}, {7'h00, rline});
        u_node.hold(1'b0, 1);
        rd_chk(16'h0245, 8'h40, 8'h00, "no edge on fall inv");
        u_node.hold(1'b1, 1);
        rd_chk(16'h0245, 8'h40, 8'h40, "edge on rise inv");
        wr_reg(16'h0245, 8'h40);
        repeat (6) @(negedge clk);
        rd_chk(16'h0245, 8'hFF, 8'h00, "edge off");
    endtask

    task automatic t_break();
        d = n_brk;
        wr_reg(16'h0245, 8'h02);
        u_node.align();
        u_node.hold(1'b0, 10);
        u_node.hold(1'b1, 12);
        rd_chk(16'h0245, 8'h80, 8'h00, "ten low no break");
        u_node.hold(1'b0, 11);
        u_node.hold(1'b1, 2);
        rd_chk(16'h0245, 8'h80, 8'h80, "eleven low break");
        wr_reg(16'h0245, 8'hC2);
        repeat (2) @(negedge clk);
        rd_chk(16'h0245, 8'hFF, 8'h02, "break cleared");
        wr_reg(16'h0245, 8'h00);
        u_node.hold(1'b0, 12);
        u_node.hold(1'b1, 2);
        rd_chk(16'h0245, 8'h80, 8'h00, "no flag when off");
        chk("break pulses", 8'h02, n_brk - d);
        wr_reg(16'h0245, 8'h40);
    endtask

    task automatic t_idle();
        stby = 1'b1;
        for (i0 = 0; i0 < 3; i0++)
        begin
            d = n_idle;
            if (i0 == 1)
                wr_reg(16'h0245, 8'h08);
            stby = (i0 < 2);
            u_node.hold(1'b0, 2);
            u_node.hold(1'b1, 12);
            chk("idle reports", {7'h00, i0 > 0}, n_idle - d);
        end
        wr_reg(16'h0245, 8'h40);
    endtask

    task automatic t_rx_gate();
        for (i0 = 0; i0 < 4; i0++)
        begin
            wr_reg(16'h0245, {5'h00, i0[1], i0[0], 1'b0});
            @(negedge clk);
            rload = 1'b1;
            ferr = 1'b1;
            #1;
            chk("full set", {7'h00, ~i0[0]}, {7'h00, rfs});
            chk("frame set", {7'h00, ~i0[0]}, {7'h00, fes});
            @(negedge clk);
            rload = 1'b0;
            ferr = 1'b0;
        end
        wr_reg(16'h0245, 8'h00);
        nine = 1'b1;
        r9 = 1'b1;
        pulse(rload);
        rd_chk(16'h0246, 8'h80, 8'h80, "rx ninth");
        r9 = 1'b0;
    endtask

    task automatic t_tx();
        for (i0 = 0; i0 < 4; i0++)
        begin
            wr_reg(16'h0245, {5'h00, i0[1], 2'h0});
            nine = i0[0];
            repeat (2) @(negedge clk);
            chk("break len", i0[1] ? (i0[0] ? 8'h0E : 8'h0D)
                : (i0[0] ? 8'h0B : 8'h0A), {4'h0, blen});
            chk("shift len", i0[0] ? 8'h0B : 8'h0A, {4'h0, slen});
            wr_reg(16'h0246, {3'h0, i0[1], 4'h0});
            txser = i0[0];
            repeat (2) @(negedge clk);
            chk("tx pin", {7'h00, i0[0] ^ i0[1]}, {7'h00, txd});
        end
        // Transmitter stays enabled so single-wire release shows the dir bit
        txen = 1'b1;
        #1;
        chk("drive dual wire", 8'h00, {7'h00, oe_n});
        lsel = 1'b1;
        lsrc = 1'b1;
        wr_reg(16'h0246, 8'h60);
        pulse(dwr);
        chk("drive enable", 8'h00, {7'h00, oe_n});
        chk("tx ninth", 8'h01, {7'h00, t9});
        wr_reg(16'h0246, 8'h00);
        pulse(dwr);
        chk("drive release", 8'h01, {7'h00, oe_n});
        chk("tx ninth low", 8'h00, {7'h00, t9});
        nine = 1'b0;
    endtask

    task automatic t_irq();
        for (i0 = 0; i0 < 4; i0++)
        begin
            fl = 4'h1 << i0;
            repeat (2) @(negedge clk);
            chk("irq masked", 8'h00, {7'h00, irq});
            wr_reg(16'h0246, 8'h01 << i0);
            repeat (2) @(negedge clk);
            chk("irq raised", 8'h01, {7'h00, irq});
            wr_reg(16'h0246, 8'h00);
            fl = 4'h0;
        end
    endtask

    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        {clk, wr, rd_s, tick, nine, lsel, lsrc, txen, txser} = 9'h000;
        {stby, ract, rload, r9, ferr, dwr} = 6'h00;
        {addr, wdata, fl, tcnt, n_fail, n_compared, n_idle, n_brk} = '0;
        rst = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_regs();
        t_edge();
        t_break();
        t_idle();
        t_rx_gate();
        t_tx();
        t_irq();
        end_of_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
endmodule
